//--- safe_state_output_control.sv
// Purpose: switching points, safe-state forcing and input discrepancy
// Assumes: apb slave on pclk, all inputs synchronous to pclk
// Notes:   one wait-free access phase; prdata loaded in the setup cycle
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

module safe_state_output_control
  import safe_out_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [31:0]         freq_one,
  input  wire logic [31:0]         freq_two,
  input  wire logic [AN_W-1:0]     analog_level,
  input  wire logic [SPLIT_W-1:0]  split_in,
  input  wire logic [2*NPAIR-1:0]  ctl_in,
  input  wire logic [2:0]          config_switch,
  input  wire logic                ext_error,
  output safe_out_t                safe_out,
  output logic                     normal_op,
  output logic                     irq
);

  logic [IDX_W-1:0]  idx;
  logic              setup_ph;
  logic              wr_acc;
  logic              prog_mode;
  logic              hit;
  logic              param_reg;
  logic [31:0]       rd_val;
  logic              ref_sel_r;
  logic [1:0]        fault_sel_r;
  logic [NPAIR-1:0]  incfg_r;
  logic [DISC_W-1:0] disc_time_r;
  logic [ST_W-1:0]   status_r;
  logic [ST_W-1:0]   mask_r;
  logic [ST_W-1:0]   ev;
  err_mode_t         mode_r;
  logic              disc_err_r;
  logic              apply;
  logic              err_w;
  logic              err_d_r;
  logic [2:0]        sw_d_r;
  logic [31:0]       fsel;
  logic [NCH-1:0]    act_r;
  logic [NPAIR-1:0]  disc_hit;
  logic [31:0]       tick_cnt_r;
  logic              tick;
  ch_cfg_t           cfg_r [NCH];
  logic [31:0]       ch_rd [NCH];
  logic [NCH-1:0]    ch_hit;

  assign idx      = paddr[IDX_W+1:2];
  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite;
  assign pready   = psel & penable;
  assign prog_mode = ~(&config_switch);
  assign normal_op = (&config_switch) & ~err_w;
  assign fsel     = ref_sel_r ? freq_two : freq_one;

  // ms tick divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 32'h0;
    end else if (tick) begin
      tick_cnt_r <= 32'h0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end
  assign tick = (tick_cnt_r == 32'(TICK_DIV - 1));

  // register decode and read mux
  always_comb begin
    hit = 1'b1;
    param_reg = 1'b1;
    rd_val = 32'h0;
    if (|ch_hit) begin
      for (int k = 0; k < NCH; k++) begin
        if (ch_hit[k]) begin
          rd_val = ch_rd[k];
        end
      end
    end else begin
      case (idx)
        IX_REF_SEL:   rd_val = {31'h0, ref_sel_r};
        IX_INCFG:     rd_val = {28'h0, incfg_r};
        IX_DISC_TIME: rd_val = {16'h0, disc_time_r};
        IX_FAULT_SEL: rd_val = {30'h0, fault_sel_r};
        IX_APPLY:     rd_val = 32'h0;
        IX_STATUS: begin
          rd_val = {27'h0, status_r};
          param_reg = 1'b0;
        end
        IX_MASK: begin
          rd_val = {27'h0, mask_r};
          param_reg = 1'b0;
        end
        IX_STATE: begin
          rd_val = {24'h0, disc_hit, disc_err_r, err_w, mode_r};
          param_reg = 1'b0;
        end
        default: begin
          hit = 1'b0;
          param_reg = 1'b0;
        end
      endcase
    end
  end

  // parameter writes only while in programming mode
  always_comb begin
    pslverr = 1'b0;
    if (psel & penable) begin
      pslverr = ~hit | (pwrite & param_reg & ~prog_mode);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (setup_ph & ~pwrite) begin
      prdata <= rd_val;
    end
  end
  logic wr_ok;
  assign wr_ok = wr_acc & ~pslverr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_sel_r   <= 1'b0;
      fault_sel_r <= FS_RST;
      incfg_r     <= '0;
      disc_time_r <= DISC_RST;
    end else if (wr_ok) begin
      case (idx)
        IX_REF_SEL:   ref_sel_r   <= pwdata[0];
        IX_FAULT_SEL: fault_sel_r <= pwdata[1:0];
        IX_INCFG:     incfg_r     <= pwdata[NPAIR-1:0];
        IX_DISC_TIME: disc_time_r <= pwdata[DISC_W-1:0];
        default: ;
      endcase
    end
  end
  assign apply = wr_ok & (idx == IX_APPLY) & pwdata[0];

  // fault injection mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= MODE_NORMAL;
    end else if (apply) begin
      case (fault_sel_r)
        FS_FORCE: mode_r <= MODE_FORCED;
        FS_CLEAR: begin
          if (mode_r == MODE_FORCED) begin
            mode_r <= MODE_CLEARED;
          end
        end
        FS_NORMAL: begin
          if (mode_r != MODE_FORCED) begin
            mode_r <= MODE_NORMAL;
          end
        end
        default: ;
      endcase
    end
  end

  assign err_w = (mode_r == MODE_FORCED) | disc_err_r | ext_error;

  // per-channel switching points and conditions
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      localparam logic [IDX_W-1:0] PIX = (gi < NOUT) ?
        IDX_W'(IX_OUT_BASE + IX_OUT_STEP * gi) : IX_REL_BASE;
      localparam logic [IDX_W-1:0] CIX = IDX_W'(IX_COND_BASE + gi);
      logic        p_sel;
      logic        h_sel;
      logic        c_sel;
      logic [31:0] lo;
      logic [32:0] hi;
      logic        set_c;
      logic        rel_c;
      assign p_sel = (idx == PIX);
      assign h_sel = (idx == PIX + IX_HYST_OFS);
      assign c_sel = (idx == CIX);
      assign ch_hit[gi] = p_sel | h_sel | c_sel;
      assign ch_rd[gi] = p_sel ? cfg_r[gi].point :
                         h_sel ? cfg_r[gi].hyst :
                         {29'h0, cfg_r[gi].hold, cfg_r[gi].over,
                          cfg_r[gi].en};
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cfg_r[gi] <= '0;
        end else if (wr_ok & p_sel) begin
          cfg_r[gi].point <= pwdata;
        end else if (wr_ok & h_sel) begin
          cfg_r[gi].hyst <= pwdata;
        end else if (wr_ok & c_sel) begin
          cfg_r[gi].en   <= pwdata[COND_EN];
          cfg_r[gi].over <= pwdata[COND_OVER];
          cfg_r[gi].hold <= pwdata[COND_HOLD];
        end
      end
      // release thresholds with hysteresis
      assign lo = (cfg_r[gi].point > cfg_r[gi].hyst) ?
                  cfg_r[gi].point - cfg_r[gi].hyst : 32'h0;
      assign hi = {1'b0, cfg_r[gi].point} + {1'b0, cfg_r[gi].hyst};
      assign set_c = cfg_r[gi].over ? (fsel > cfg_r[gi].point)
                                    : (fsel < cfg_r[gi].point);
      assign rel_c = cfg_r[gi].over ? (fsel < lo)
                                    : ({1'b0, fsel} > hi);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          act_r[gi] <= 1'b0;
        end else if (!cfg_r[gi].en) begin
          act_r[gi] <= 1'b0;
        end else if (set_c) begin
          act_r[gi] <= 1'b1;
        end else if (cfg_r[gi].hold) begin
          if (apply & (fault_sel_r == FS_CLEAR)) begin
            act_r[gi] <= 1'b0;
          end
        end else if (rel_c) begin
          act_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // two-pole input discrepancy, pairs must be antivalent
  genvar gj;
  generate
    for (gj = 0; gj < NPAIR; gj++) begin : g_pair
      logic [DISC_W-1:0] cnt_r;
      logic              illegal;
      assign illegal = incfg_r[gj] & (ctl_in[2*gj] == ctl_in[2*gj+1]);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_r <= '0;
        end else if (!illegal) begin
          cnt_r <= '0;
        end else if (tick & ~disc_hit[gj]) begin
          cnt_r <= cnt_r + 16'h1;
        end
      end
      assign disc_hit[gj] = illegal & (cnt_r > disc_time_r);
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disc_err_r <= 1'b0;
    end else if (|disc_hit) begin
      disc_err_r <= 1'b1;
    end else if (apply & (fault_sel_r == FS_CLEAR)) begin
      disc_err_r <= 1'b0;
    end
  end

  // safe-state outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      safe_out <= '0;
    end else if (err_w) begin
      safe_out.analog       <= '0;
      safe_out.relay_closed <= 2'h0;
      safe_out.ctl          <= '0;
      safe_out.ctl_n        <= '0;
      safe_out.split        <= '0;
    end else begin
      safe_out.analog       <= analog_level;
      safe_out.relay_closed <= {2{~act_r[NCH-1]}};
      safe_out.ctl          <= act_r[NOUT-1:0];
      safe_out.ctl_n        <= ~act_r[NOUT-1:0];
      safe_out.split        <= split_in;
    end
  end

  // events and interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_d_r <= 1'b0;
      sw_d_r  <= 3'h7;
    end else begin
      err_d_r <= err_w;
      sw_d_r  <= config_switch;
    end
  end

  always_comb begin
    ev = '0;
    ev[ST_ERR_SET]    = err_w & ~err_d_r;
    ev[ST_ERR_CLR]    = ~err_w & err_d_r;
    ev[ST_PROG_EXIT]  = config_switch[2] & ~sw_d_r[2] &
                        (&config_switch[1:0]);
    ev[ST_DISC]       = |disc_hit & ~disc_err_r;
    ev[ST_RELAY_OPEN] = (err_w | act_r[NCH-1]) &
                        ~(err_d_r | safe_out.relay_closed == 2'h0);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= '0;
      mask_r   <= '0;
    end else begin
      if (wr_ok & (idx == IX_STATUS)) begin
        status_r <= (status_r & ~pwdata[ST_W-1:0]) | ev;
      end else begin
        status_r <= status_r | ev;
      end
      if (wr_ok & (idx == IX_MASK)) begin
        mask_r <= pwdata[ST_W-1:0];
      end
    end
  end

  assign irq = |(status_r & mask_r);
  // checks
  sequence s_force;
    apply && fault_sel_r == FS_FORCE;
  endsequence
  sequence s_clear;
    apply && fault_sel_r == FS_CLEAR;
  endsequence
  a_force_entry: assert property (@(posedge pclk) disable iff (!presetn)
    s_force |=> mode_r == MODE_FORCED ##1 safe_out.ctl == '0)
    else $error("forced error not entered");
  a_clear_exit: assert property (@(posedge pclk) disable iff (!presetn)
    s_clear and mode_r == MODE_FORCED |=> mode_r == MODE_CLEARED)
    else $error("forced error not cleared");
  a_normal_return: assert property (@(posedge pclk) disable iff (!presetn)
    apply && fault_sel_r == FS_NORMAL && mode_r != MODE_FORCED
    |=> mode_r == MODE_NORMAL)
    else $error("normal code did not return to normal");
  a_analog_zero: assert property (@(posedge pclk) disable iff (!presetn)
    err_w |=> safe_out.analog == '0)
    else $error("analog output not zero in error");
  a_relay_error: assert property (@(posedge pclk) disable iff (!presetn)
    err_w |=> safe_out.relay_closed == 2'h0)
    else $error("relay closed during error");
  a_ctl_low: assert property (@(posedge pclk) disable iff (!presetn)
    err_w |=> (safe_out.ctl | safe_out.ctl_n) == '0)
    else $error("control output high during error");
  a_split_low: assert property (@(posedge pclk) disable iff (!presetn)
    err_w |=> safe_out.split == '0)
    else $error("splitter line high during error");
  a_relay_cond: assert property (@(posedge pclk) disable iff (!presetn)
    act_r[NCH-1] |=> safe_out.relay_closed == 2'h0)
    else $error("relay closed with condition true");
  a_prog_exit: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(config_switch[2]) && &config_switch[1:0]
    |=> status_r[ST_PROG_EXIT])
    else $error("programming exit not flagged");
  a_normal_flag: assert property (@(posedge pclk) disable iff (!presetn)
    normal_op |-> &config_switch && !disc_err_r)
    else $error("normal flag outside normal setting");
  a_disc_tol: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(disc_err_r) |-> $past(disc_hit) != '0 && !normal_op)
    else $error("discrepancy error without expiry");
  a_forced_hold: assert property (@(posedge pclk) disable iff (!presetn)
    mode_r == MODE_FORCED && !(apply && fault_sel_r == FS_CLEAR)
    |=> mode_r == MODE_FORCED)
    else $error("forced error released without clear");
endmodule

//--- safe_out_pkg.sv
// Purpose: shared constants and types of the safe-state output control
// Assumes: register index = parameter number, byte address = 4 * index
// Notes:   frequencies are unsigned 32-bit values in the same unit
package safe_out_pkg;

  localparam int NCH       = 5;   // four control outputs plus the relay
  localparam int NOUT      = 4;
  localparam int NPAIR     = 4;   // eight control inputs as four pairs
  localparam int IDX_W     = 8;
  localparam int DISC_W    = 16;
  localparam int AN_W      = 16;
  localparam int SPLIT_W   = 6;
  localparam int ST_W      = 5;

  // register indices
  localparam logic [IDX_W-1:0] IX_REF_SEL   = 8'h02; // 002
  localparam logic [IDX_W-1:0] IX_OUT_BASE  = 8'h29; // 041
  localparam logic [IDX_W-1:0] IX_OUT_STEP  = 8'h14; // 20 per output
  localparam logic [IDX_W-1:0] IX_REL_BASE  = 8'h79; // 121
  localparam logic [IDX_W-1:0] IX_COND_BASE = 8'h8d; // 141
  localparam logic [IDX_W-1:0] IX_INCFG     = 8'hba; // 186
  localparam logic [IDX_W-1:0] IX_DISC_TIME = 8'hbb; // 187
  localparam logic [IDX_W-1:0] IX_FAULT_SEL = 8'hd0;
  localparam logic [IDX_W-1:0] IX_APPLY     = 8'hd1;
  localparam logic [IDX_W-1:0] IX_STATUS    = 8'hd2;
  localparam logic [IDX_W-1:0] IX_MASK      = 8'hd3;
  localparam logic [IDX_W-1:0] IX_STATE     = 8'hd4;
  localparam logic [IDX_W-1:0] IX_HYST_OFS  = 8'h01;

  // fault injection codes
  localparam logic [1:0] FS_FORCE  = 2'h0;
  localparam logic [1:0] FS_NORMAL = 2'h1;
  localparam logic [1:0] FS_CLEAR  = 2'h2;
  localparam logic [1:0] FS_RST    = 2'h1;

  // switching condition fields
  localparam int COND_EN   = 0;
  localparam int COND_OVER = 1;
  localparam int COND_HOLD = 2;

  // status bits
  localparam int ST_ERR_SET    = 0;
  localparam int ST_ERR_CLR    = 1;
  localparam int ST_PROG_EXIT  = 2;
  localparam int ST_DISC       = 3;
  localparam int ST_RELAY_OPEN = 4;

  localparam logic [DISC_W-1:0] DISC_RST = 16'h0064;

  // millisecond tick for the discrepancy time
  localparam int TICK_NS       = 1000000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_FORCED,
    MODE_CLEARED
  } err_mode_t;

  typedef struct packed {
    logic [31:0] point;
    logic [31:0] hyst;
    logic        en;
    logic        over;
    logic        hold;
  } ch_cfg_t;

  typedef struct packed {
    logic [1:0]         relay_closed;
    logic [NOUT-1:0]    ctl;
    logic [NOUT-1:0]    ctl_n;
    logic [SPLIT_W-1:0] split;
    logic [AN_W-1:0]    analog;
  } safe_out_t;

endpackage

//--- safe_circuit_model.sv
// Purpose: downstream safety circuit fed by the safe-state outputs
// Assumes: both relay contacts in series, analog loop live when nonzero
// Notes:   passive observer, drives nothing back into the block
`timescale 1ns/1ps
module safe_circuit_model
  import safe_out_pkg::*;
(
  input  wire logic      pclk,
  input  wire safe_out_t safe_out,
  output logic           circuit_closed,
  output logic           loop_live
);
  // either open contact breaks the chain
  always_ff @(posedge pclk) begin
    circuit_closed <= &safe_out.relay_closed;
    loop_live      <= |safe_out.analog;
  end
endmodule

//--- tb_safe_state_output_control.sv
// Purpose: register-level tests of the safe-state output control
// Assumes: apb master on pclk, tick divider shortened to 10 cycles
// Notes:   expectations follow the safe state and the fault codes
`timescale 1ns/1ps
module tb_safe_state_output_control
  import safe_out_pkg::*;
;
  logic                pclk;
  logic                presetn;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [11:0]         paddr;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic [31:0]         freq_one;
  logic [31:0]         freq_two;
  logic [2*NPAIR-1:0]  ctl_in;
  logic [2:0]          config_switch;
  logic                ext_error;
  safe_out_t           safe_out;
  logic                normal_op;
  logic                irq;
  logic                circuit_closed;
  logic                loop_live;
  logic [31:0]         rd;
  logic                er;
  int                  mismatches;
  int                  n_checks;
  localparam logic [7:0] PIX [7] = '{8'h29, 8'h3d, 8'h51, 8'h65,
                                     8'h79, 8'h8d, 8'hba};

  safe_state_output_control #(.TICK_DIV(10)) i_safe_state_output_control (
    .pclk          (pclk),
    .presetn       (presetn),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .freq_one      (freq_one),
    .freq_two      (freq_two),
    .analog_level  (16'h1234),
    .split_in      (6'h2d),
    .ctl_in        (ctl_in),
    .config_switch (config_switch),
    .ext_error     (ext_error),
    .safe_out      (safe_out),
    .normal_op     (normal_op),
    .irq           (irq)
  );

  safe_circuit_model i_safe_circuit_model (
    .pclk           (pclk),
    .safe_out       (safe_out),
    .circuit_closed (circuit_closed),
    .loop_live      (loop_live)
  );

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic xfer(input logic w, input logic [7:0] ix,
                      input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, ix, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
  endtask

  task automatic idle(input int n);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // fault code then apply pulse, outputs settle within a few edges
  task automatic apply(input logic [1:0] code);
    xfer(1'b1, IX_FAULT_SEL, {30'h0, code});
    xfer(1'b1, IX_APPLY, 32'h1);
    idle(4);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    mismatches++;
    tally_and_finish;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    freq_one = 32'd500;
    freq_two = 32'd2000;
    ctl_in = 8'h55;
    config_switch = 3'b011;
    ext_error = 1'b0;
    mismatches = 0;
    n_checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1'b0, IX_FAULT_SEL, 32'h0);
    chk("fault_sel", rd, 32'h1);
    xfer(1'b0, IX_STATE, 32'h0);
    chk("mode", {30'h0, rd[1:0]}, 32'h0);
    idle(2);
    chk("irq", irq, 1'b0);
    chk("normal_op", normal_op, 1'b0);
    chk("analog", safe_out.analog, 16'h1234);
    chk("relay", safe_out.relay_closed, 2'b11);
    $display("test reset done");
    for (int i = 0; i < 7; i++)
      xfer(1'b1, PIX[i], 32'(i + 1));
    for (int i = 0; i < 7; i++) begin
      xfer(1'b0, PIX[i], 32'h0);
      chk("param", rd, 32'(i + 1));
    end
    $display("test blocks done");
    xfer(1'b1, IX_MASK, 32'h1);
    apply(FS_FORCE);
    chk("analog", safe_out.analog, 16'h0);
    chk("relay", safe_out.relay_closed, 2'b00);
    chk("circuit", circuit_closed, 1'b0);
    chk("ctl", {safe_out.ctl, safe_out.ctl_n}, 8'h0);
    chk("split", safe_out.split, 6'h0);
    chk("irq", irq, 1'b1);
    xfer(1'b0, IX_STATE, 32'h0);
    chk("mode", {30'h0, rd[1:0]}, 32'h1);
    apply(FS_NORMAL);
    chk("latched", loop_live, 1'b0);
    xfer(1'b0, IX_STATE, 32'h0);
    chk("mode", {30'h0, rd[1:0]}, 32'h1);
    xfer(1'b1, IX_STATUS, 32'h1);
    idle(2);
    chk("irq", irq, 1'b0);
    apply(FS_CLEAR);
    chk("analog", safe_out.analog, 16'h1234);
    chk("split", safe_out.split, 6'h2d);
    xfer(1'b0, IX_STATE, 32'h0);
    chk("mode", {30'h0, rd[1:0]}, 32'h2);
    apply(FS_NORMAL);
    xfer(1'b0, IX_STATE, 32'h0);
    chk("mode", {30'h0, rd[1:0]}, 32'h0);
    $display("test force done");
    xfer(1'b1, IX_REL_BASE, 32'd1000);
    xfer(1'b1, IX_REL_BASE + IX_HYST_OFS, 32'd100);
    xfer(1'b1, IX_COND_BASE + 8'h04, 32'h3);
    xfer(1'b1, IX_REF_SEL, 32'h0);
    idle(4);
    chk("relay", safe_out.relay_closed, 2'b11);
    xfer(1'b1, IX_REF_SEL, 32'h1);
    idle(4);
    chk("relay", safe_out.relay_closed, 2'b00);
    freq_two <= 32'd950;
    idle(4);
    chk("relay", safe_out.relay_closed, 2'b00);
    freq_two <= 32'd850;
    idle(4);
    chk("relay", safe_out.relay_closed, 2'b11);
    xfer(1'b1, IX_COND_BASE + 8'h04, 32'h0);
    $display("test relay done");
    xfer(1'b1, PIX[0], 32'd1000);
    xfer(1'b1, IX_COND_BASE, 32'h5);
    idle(4);
    chk("ctl", {safe_out.ctl, safe_out.ctl_n}, 8'h1e);
    freq_two <= 32'd2000;
    idle(4);
    chk("hold", {safe_out.ctl, safe_out.ctl_n}, 8'h1e);
    apply(FS_CLEAR);
    chk("hold", {safe_out.ctl, safe_out.ctl_n}, 8'h0f);
    xfer(1'b1, IX_COND_BASE, 32'h0);
    $display("test hold done");
    xfer(1'b1, IX_DISC_TIME, 32'd3);
    ctl_in <= 8'h54;
    idle(20);
    xfer(1'b0, IX_STATE, 32'h0);
    chk("disc", rd[3], 1'b0);
    idle(60);
    xfer(1'b0, IX_STATE, 32'h0);
    chk("disc", rd[3], 1'b1);
    chk("relay", safe_out.relay_closed, 2'b00);
    ctl_in <= 8'h55;
    apply(FS_CLEAR);
    apply(FS_NORMAL);
    xfer(1'b0, IX_STATE, 32'h0);
    chk("disc", rd[3], 1'b0);
    $display("test discrepancy done");
    config_switch <= 3'b111;
    idle(2);
    chk("normal_op", normal_op, 1'b1);
    xfer(1'b0, IX_STATUS, 32'h0);
    chk("prog_exit", rd[2], 1'b1);
    ext_error <= 1'b1;
    idle(2);
    chk("normal_op", normal_op, 1'b0);
    chk("relay", safe_out.relay_closed, 2'b00);
    chk("analog", safe_out.analog, 16'h0);
    ext_error <= 1'b0;
    idle(2);
    chk("normal_op", normal_op, 1'b1);
    chk("relay", safe_out.relay_closed, 2'b11);
    xfer(1'b1, PIX[0], 32'h9);
    chk("refused", er, 1'b1);
    xfer(1'b0, PIX[0], 32'h0);
    chk("kept", rd, 32'd1000);
    xfer(1'b0, 8'hff, 32'h0);
    chk("unmapped", er, 1'b1);
    config_switch <= 3'b101;
    idle(2);
    chk("normal_op", normal_op, 1'b0);
    $display("test switch done");
    tally_and_finish;
  end
endmodule
